// File: rtl/mssx_cfg.svh
// Constants for the swap, skip, table read and exclusive-or execution unit.
`ifndef MSSX_CFG_SVH
`define MSSX_CFG_SVH
`define MSSX_DATA_W      8
`define MSSX_ROM_W       15
`define MSSX_PAGE_W      4
`define MSSX_PTR_W       8
`define MSSX_BIT_W       3
`define MSSX_LAST_PAGE   4'hF
`define MSSX_ACC_RST     8'h00
`define MSSX_TABLE_HIGH_BYTE_RST    7'h00
`define MSSX_BYTE_ZERO   8'h00
`define MSSX_LOW_LSB     0
`define MSSX_LOW_MSB     7
`define MSSX_HIGH_LSB    8
`define MSSX_HIGH_MSB    14
`define MSSX_NIB_LO_MSB  3
`define MSSX_NIB_HI_LSB  4
`endif

// File: rtl/mssx_pkg.sv
// Types for the swap, skip, table read and exclusive-or execution unit.
package mssx_pkg;
	typedef enum logic [3:0] {
		MSSX_OP_NOP,
		MSSX_OP_NIBBLE_SWAP_TO_ACC,
		MSSX_OP_SKIP_IF_ZERO,
		MSSX_OP_SKIP_IF_ZERO_MOVE_ACC,
		MSSX_OP_SKIP_IF_BIT_CLEAR,
		MSSX_OP_TABLE_READ_CURRENT_PAGE,
		MSSX_OP_TABLE_READ_LAST_PAGE,
		MSSX_OP_XOR_TO_ACC,
		MSSX_OP_XOR_TO_MEMORY,
		MSSX_OP_XOR_IMMEDIATE
	} mssx_op_type;

	typedef enum {
		MSSX_ST_IDLE,
		MSSX_ST_DUMMY,
		MSSX_ST_TABLE_WAIT
	} mssx_state_type;
endpackage : mssx_pkg

// File: rtl/mssx_exec.sv
// Execution unit for nibble swap, zero skips, table reads and exclusive-or forms.
//
// Summary of operation
// - Swap data byte nibbles into accumulator only.
// - Skip next instruction when data byte zero.
// - Copy byte to accumulator, skip when zero.
// - Skip next instruction when selected bit clear.
// - Taken skip inserts dummy, costing two cycles.
// - Current page table read to memory, high.
// - Last page table read to memory, high.
// - Accumulator xor memory into accumulator, zero flag.
// - Accumulator xor memory into memory, zero flag.
// - Accumulator xor immediate into accumulator, zero flag.
`timescale 1ns/1ns
`default_nettype none
`include "mssx_cfg.svh"

module mssx_exec #(
	parameter int DATA_W = `MSSX_DATA_W,
	parameter int ROM_W  = `MSSX_ROM_W,
	parameter int PAGE_W = `MSSX_PAGE_W,
	parameter int PTR_W  = `MSSX_PTR_W
) (
	input  wire logic                    CORE_CLK_IN,
	input  wire logic                    RST_N_IN,
	input  wire logic                    EXEC_VALID_IN,
	input  wire mssx_pkg::mssx_op_type   OP_IN,
	input  wire logic [DATA_W-1:0]       MEM_DATA_IN,
	input  wire logic [`MSSX_BIT_W-1:0]  BIT_SEL_IN,
	input  wire logic [DATA_W-1:0]       IMM_IN,
	input  wire logic [PTR_W-1:0]        TABLE_POINTER_IN,
	input  wire logic [PAGE_W-1:0]       CUR_PAGE_IN,
	input  wire logic [ROM_W-1:0]        ROM_DATA_IN,
	input  wire logic                    ROM_VALID_IN,
	output logic [DATA_W-1:0]            ACC_OUT,
	output logic                         ZERO_FLAG_OUT,
	output logic                         MEM_WR_OUT,
	output logic [DATA_W-1:0]            MEM_WDATA_OUT,
	output logic [ROM_W-DATA_W-1:0]      TABLE_HIGH_BYTE_OUT,
	output logic                         ROM_REQ_OUT,
	output logic [PAGE_W+PTR_W-1:0]      ROM_ADDR_OUT,
	output logic                         SKIP_OUT,
	output logic                         BUSY_OUT,
	output logic                         DONE_OUT
);
	import mssx_pkg::*;

	mssx_state_type                 state_r;
	mssx_state_type                 state_nxt;
	logic [DATA_W-1:0]              acc_r;
	logic [DATA_W-1:0]              acc_nxt;
	logic                           zero_r;
	logic                           zero_nxt;
	logic                           mem_wr_r;
	logic                           mem_wr_nxt;
	logic [DATA_W-1:0]              mem_wdata_r;
	logic [DATA_W-1:0]              mem_wdata_nxt;
	logic [ROM_W-DATA_W-1:0]        table_high_byte_r;
	logic [ROM_W-DATA_W-1:0]        table_high_byte_nxt;
	logic                           rom_req_r;
	logic                           rom_req_nxt;
	logic [PAGE_W+PTR_W-1:0]        rom_addr_r;
	logic [PAGE_W+PTR_W-1:0]        rom_addr_nxt;
	logic                           skip_r;
	logic                           skip_nxt;
	logic                           busy_r;
	logic                           busy_nxt;
	logic                           done_r;
	logic                           done_nxt;
	logic [DATA_W-1:0]              xor_mem;
	logic [DATA_W-1:0]              xor_imm;

	// Zero test shared by the two zero skips and the zero flag update.
	function automatic logic is_zero(input logic [DATA_W-1:0] value);
		is_zero = (value == `MSSX_BYTE_ZERO);
	endfunction : is_zero

	assign xor_mem = acc_r ^ MEM_DATA_IN;
	assign xor_imm = acc_r ^ IMM_IN;

	always_comb begin
		state_nxt     = state_r;
		acc_nxt       = acc_r;
		zero_nxt      = zero_r;
		mem_wr_nxt    = 1'b0;
		mem_wdata_nxt = mem_wdata_r;
		table_high_byte_nxt      = table_high_byte_r;
		rom_req_nxt   = rom_req_r;
		rom_addr_nxt  = rom_addr_r;
		skip_nxt      = 1'b0;
		busy_nxt      = busy_r;
		done_nxt      = 1'b0;
		case (state_r)
			MSSX_ST_IDLE: begin
				busy_nxt = 1'b0;
				if (EXEC_VALID_IN) begin
					case (OP_IN)
						MSSX_OP_NIBBLE_SWAP_TO_ACC: begin
							acc_nxt  = {MEM_DATA_IN[`MSSX_NIB_LO_MSB:0],
								MEM_DATA_IN[DATA_W-1:`MSSX_NIB_HI_LSB]};
							done_nxt = 1'b1;
						end
						MSSX_OP_SKIP_IF_ZERO: begin
							if (is_zero(MEM_DATA_IN)) begin
								skip_nxt  = 1'b1;
								busy_nxt  = 1'b1;
								state_nxt = MSSX_ST_DUMMY;
							end else begin
								done_nxt = 1'b1;
							end
						end
						MSSX_OP_SKIP_IF_ZERO_MOVE_ACC: begin
							acc_nxt = MEM_DATA_IN;
							if (is_zero(MEM_DATA_IN)) begin
								skip_nxt  = 1'b1;
								busy_nxt  = 1'b1;
								state_nxt = MSSX_ST_DUMMY;
							end else begin
								done_nxt = 1'b1;
							end
						end
						MSSX_OP_SKIP_IF_BIT_CLEAR: begin
							if (!MEM_DATA_IN[BIT_SEL_IN]) begin
								skip_nxt  = 1'b1;
								busy_nxt  = 1'b1;
								state_nxt = MSSX_ST_DUMMY;
							end else begin
								done_nxt = 1'b1;
							end
						end
						MSSX_OP_TABLE_READ_CURRENT_PAGE: begin
							rom_addr_nxt = {CUR_PAGE_IN, TABLE_POINTER_IN};
							rom_req_nxt  = 1'b1;
							busy_nxt     = 1'b1;
							state_nxt    = MSSX_ST_TABLE_WAIT;
						end
						MSSX_OP_TABLE_READ_LAST_PAGE: begin
							rom_addr_nxt = {`MSSX_LAST_PAGE, TABLE_POINTER_IN};
							rom_req_nxt  = 1'b1;
							busy_nxt     = 1'b1;
							state_nxt    = MSSX_ST_TABLE_WAIT;
						end
						MSSX_OP_XOR_TO_ACC: begin
							acc_nxt  = xor_mem;
							zero_nxt = is_zero(xor_mem);
							done_nxt = 1'b1;
						end
						MSSX_OP_XOR_TO_MEMORY: begin
							mem_wdata_nxt = xor_mem;
							mem_wr_nxt    = 1'b1;
							zero_nxt      = is_zero(xor_mem);
							done_nxt      = 1'b1;
						end
						MSSX_OP_XOR_IMMEDIATE: begin
							acc_nxt  = xor_imm;
							zero_nxt = is_zero(xor_imm);
							done_nxt = 1'b1;
						end
						default: begin
							done_nxt = 1'b1;
						end
					endcase
				end
			end
			// The instruction fetched behind a taken skip is discarded here, so any
			// request presented in this cycle is ignored rather than executed.
			MSSX_ST_DUMMY: begin
				busy_nxt  = 1'b0;
				done_nxt  = 1'b1;
				state_nxt = MSSX_ST_IDLE;
			end
			// The wait has no timeout; a program memory that never answers stalls the unit.
			MSSX_ST_TABLE_WAIT: begin
				if (ROM_VALID_IN) begin
					mem_wdata_nxt = ROM_DATA_IN[`MSSX_LOW_MSB:`MSSX_LOW_LSB];
					table_high_byte_nxt      = ROM_DATA_IN[`MSSX_HIGH_MSB:`MSSX_HIGH_LSB];
					mem_wr_nxt    = 1'b1;
					rom_req_nxt   = 1'b0;
					busy_nxt      = 1'b0;
					done_nxt      = 1'b1;
					state_nxt     = MSSX_ST_IDLE;
				end
			end
			default: begin
				state_nxt = MSSX_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			state_r     <= MSSX_ST_IDLE;
			acc_r       <= `MSSX_ACC_RST;
			zero_r      <= 1'b0;
			mem_wr_r    <= 1'b0;
			mem_wdata_r <= `MSSX_BYTE_ZERO;
			table_high_byte_r      <= `MSSX_TABLE_HIGH_BYTE_RST;
			rom_req_r   <= 1'b0;
			rom_addr_r  <= '0;
			skip_r      <= 1'b0;
			busy_r      <= 1'b0;
			done_r      <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			acc_r       <= acc_nxt;
			zero_r      <= zero_nxt;
			mem_wr_r    <= mem_wr_nxt;
			mem_wdata_r <= mem_wdata_nxt;
			table_high_byte_r      <= table_high_byte_nxt;
			rom_req_r   <= rom_req_nxt;
			rom_addr_r  <= rom_addr_nxt;
			skip_r      <= skip_nxt;
			busy_r      <= busy_nxt;
			done_r      <= done_nxt;
		end
	end

	assign ACC_OUT             = acc_r;
	assign ZERO_FLAG_OUT       = zero_r;
	assign MEM_WR_OUT          = mem_wr_r;
	assign MEM_WDATA_OUT       = mem_wdata_r;
	assign TABLE_HIGH_BYTE_OUT = table_high_byte_r;
	assign ROM_REQ_OUT         = rom_req_r;
	assign ROM_ADDR_OUT        = rom_addr_r;
	assign SKIP_OUT            = skip_r;
	assign BUSY_OUT            = busy_r;
	assign DONE_OUT            = done_r;
endmodule : mssx_exec
`default_nettype wire

// File: tb/mssx_exec_props.sv
// Checker for the swap, skip, table read and exclusive-or execution unit.
`timescale 1ns/1ns
`default_nettype none
module mssx_exec_props (
	input wire logic                  CORE_CLK_IN,
	input wire logic                  RST_N_IN,
	input wire logic                  EXEC_VALID_IN,
	input wire mssx_pkg::mssx_op_type OP_IN,
	input wire logic [7:0]            MEM_DATA_IN,
	input wire logic [2:0]            BIT_SEL_IN,
	input wire logic [7:0]            IMM_IN,
	input wire logic [14:0]           ROM_DATA_IN,
	input wire logic                  ROM_VALID_IN,
	input wire logic [7:0]            ACC_OUT,
	input wire logic                  ZERO_FLAG_OUT,
	input wire logic                  MEM_WR_OUT,
	input wire logic [7:0]            MEM_WDATA_OUT,
	input wire logic [6:0]            TABLE_HIGH_BYTE_OUT,
	input wire logic                  ROM_REQ_OUT,
	input wire logic                  SKIP_OUT,
	input wire logic                  BUSY_OUT,
	input wire logic                  DONE_OUT
);
	import mssx_pkg::*;
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	// Busy marks the dummy cycle and the table wait, where requests are refused.
	wire logic       go    = EXEC_VALID_IN && !BUSY_OUT;
	wire logic       bit_v = MEM_DATA_IN[BIT_SEL_IN];
	wire logic [7:0] swp   = {MEM_DATA_IN[3:0], MEM_DATA_IN[7:4]};
	a_swap_nibbles: assert property (go && OP_IN == MSSX_OP_NIBBLE_SWAP_TO_ACC |=>
		ACC_OUT == $past(swp) && $stable(ZERO_FLAG_OUT)) else $error("swap wrong");
	a_skip_dummy: assert property (go && OP_IN == MSSX_OP_SKIP_IF_ZERO && MEM_DATA_IN == '0 |=>
		SKIP_OUT && BUSY_OUT && !DONE_OUT ##1 DONE_OUT && !BUSY_OUT) else $error("skip wrong");
	a_move_acc: assert property (go && OP_IN == MSSX_OP_SKIP_IF_ZERO_MOVE_ACC |=>
		ACC_OUT == $past(MEM_DATA_IN) && SKIP_OUT == (ACC_OUT == '0)) else $error("move wrong");
	a_bit_clear: assert property (go && OP_IN == MSSX_OP_SKIP_IF_BIT_CLEAR |=>
		SKIP_OUT != $past(bit_v)) else $error("bit skip wrong");
	a_xor_acc: assert property (go && OP_IN == MSSX_OP_XOR_TO_ACC |=>
		ACC_OUT == ($past(ACC_OUT) ^ $past(MEM_DATA_IN)) && ZERO_FLAG_OUT == (ACC_OUT == '0))
		else $error("xor acc wrong");
	a_xor_mem: assert property (go && OP_IN == MSSX_OP_XOR_TO_MEMORY |=> MEM_WR_OUT &&
		MEM_WDATA_OUT == ($past(ACC_OUT) ^ $past(MEM_DATA_IN)) && $stable(ACC_OUT)
		&& ZERO_FLAG_OUT == (MEM_WDATA_OUT == '0)) else $error("xor mem wrong");
	a_xor_imm: assert property (go && OP_IN == MSSX_OP_XOR_IMMEDIATE |=>
		ACC_OUT == ($past(ACC_OUT) ^ $past(IMM_IN)) && ZERO_FLAG_OUT == (ACC_OUT == '0))
		else $error("xor imm wrong");
	a_table_store: assert property (ROM_REQ_OUT && ROM_VALID_IN |=> DONE_OUT && MEM_WR_OUT &&
		{TABLE_HIGH_BYTE_OUT, MEM_WDATA_OUT} == $past(ROM_DATA_IN)) else $error("table wrong");
	c_skip: cover property (SKIP_OUT);
	c_table: cover property (ROM_REQ_OUT && ROM_VALID_IN);
	c_zero: cover property (DONE_OUT && ZERO_FLAG_OUT);
endmodule : mssx_exec_props
`default_nettype wire

// File: tb/test_mcu_swap_skip_table_xor_ops.sv
// Testbench for the swap, skip, table read and exclusive-or execution unit.
`timescale 1ns/1ns
`default_nettype none
module test_mcu_swap_skip_table_xor_ops;
	import mssx_pkg::*;
	logic        CORE_CLK_IN = '0, RST_N_IN = '0, EXEC_VALID_IN = '0, ROM_VALID_IN = '0;
	logic        ZERO_FLAG_OUT, MEM_WR_OUT, ROM_REQ_OUT, SKIP_OUT, BUSY_OUT, DONE_OUT;
	logic [2:0]  BIT_SEL_IN = '0;
	logic [3:0]  CUR_PAGE_IN = '0;
	logic [6:0]  TABLE_HIGH_BYTE_OUT;
	logic [7:0]  MEM_DATA_IN = '0, IMM_IN = '0, TABLE_POINTER_IN = '0, ACC_OUT, MEM_WDATA_OUT;
	logic [11:0] ROM_ADDR_OUT;
	logic [14:0] ROM_DATA_IN = '0;
	mssx_op_type OP_IN = MSSX_OP_NOP;
	int          error_cnt = 0, comparisons = 0;
	mssx_exec uut (
		.CORE_CLK_IN         (CORE_CLK_IN),
		.RST_N_IN            (RST_N_IN),
		.EXEC_VALID_IN       (EXEC_VALID_IN),
		.OP_IN               (OP_IN),
		.MEM_DATA_IN         (MEM_DATA_IN),
		.BIT_SEL_IN          (BIT_SEL_IN),
		.IMM_IN              (IMM_IN),
		.TABLE_POINTER_IN    (TABLE_POINTER_IN),
		.CUR_PAGE_IN         (CUR_PAGE_IN),
		.ROM_DATA_IN         (ROM_DATA_IN),
		.ROM_VALID_IN        (ROM_VALID_IN),
		.ACC_OUT             (ACC_OUT),
		.ZERO_FLAG_OUT       (ZERO_FLAG_OUT),
		.MEM_WR_OUT          (MEM_WR_OUT),
		.MEM_WDATA_OUT       (MEM_WDATA_OUT),
		.TABLE_HIGH_BYTE_OUT (TABLE_HIGH_BYTE_OUT),
		.ROM_REQ_OUT         (ROM_REQ_OUT),
		.ROM_ADDR_OUT        (ROM_ADDR_OUT),
		.SKIP_OUT            (SKIP_OUT),
		.BUSY_OUT            (BUSY_OUT),
		.DONE_OUT            (DONE_OUT)
	);
	initial forever #20 CORE_CLK_IN = ~CORE_CLK_IN;
	task automatic tick;
		@(posedge CORE_CLK_IN);
		#1;
	endtask : tick
	task automatic ck(input logic [14:0] got, input logic [14:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : ck
	// Valid stays high between requests so it never toggles within one time step;
	// the dummy cycle and the table wait must refuse whatever is left presented.
	task automatic go(input mssx_op_type op, input logic [7:0] m);
		OP_IN = op;
		MEM_DATA_IN = m;
		EXEC_VALID_IN = '1;
		tick;
	endtask : go
	task automatic stop_test;
		$display("Comparisons %0d, errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	task automatic t_xor;
		go(MSSX_OP_XOR_TO_ACC, 8'h5A);
		ck({ZERO_FLAG_OUT, ACC_OUT}, 9'h05A);
		go(MSSX_OP_XOR_TO_ACC, 8'h5A);
		ck({ZERO_FLAG_OUT, ACC_OUT}, 9'h100);
		go(MSSX_OP_XOR_TO_ACC, 8'h0F);
		go(MSSX_OP_XOR_TO_MEMORY, 8'hFF);
		ck({MEM_WR_OUT, MEM_WDATA_OUT}, 9'h1F0);
		ck({ZERO_FLAG_OUT, ACC_OUT}, 9'h00F);
		IMM_IN = 8'h0F;
		go(MSSX_OP_XOR_IMMEDIATE, 8'h00);
		ck({ZERO_FLAG_OUT, ACC_OUT}, 9'h100);
		$display("xor test done");
	endtask : t_xor
	task automatic t_swap;
		go(MSSX_OP_NIBBLE_SWAP_TO_ACC, 8'h3C);
		ck({ZERO_FLAG_OUT, ACC_OUT, MEM_WR_OUT}, 10'h386);
		$display("swap test done");
	endtask : t_swap
	task automatic t_skip;
		go(MSSX_OP_SKIP_IF_ZERO, 8'h00);
		ck({SKIP_OUT, BUSY_OUT, DONE_OUT}, 3'h6);
		go(MSSX_OP_XOR_TO_ACC, 8'hFF);
		ck({DONE_OUT, ACC_OUT}, 9'h1C3);
		go(MSSX_OP_SKIP_IF_ZERO, 8'h01);
		ck({SKIP_OUT, BUSY_OUT, DONE_OUT}, 3'h1);
		BIT_SEL_IN = 3'h3;
		go(MSSX_OP_SKIP_IF_BIT_CLEAR, 8'hF7);
		ck({SKIP_OUT, ZERO_FLAG_OUT}, 2'h3);
		tick;
		go(MSSX_OP_SKIP_IF_BIT_CLEAR, 8'h08);
		ck(SKIP_OUT, 1'h0);
		go(MSSX_OP_SKIP_IF_ZERO_MOVE_ACC, 8'h7E);
		ck({SKIP_OUT, ACC_OUT}, 9'h07E);
		go(MSSX_OP_SKIP_IF_ZERO_MOVE_ACC, 8'h00);
		ck({SKIP_OUT, ACC_OUT}, 9'h100);
		tick;
		$display("skip test done");
	endtask : t_skip
	// Program memory answers two cycles late to exercise the wait.
	task automatic rd_tab(input mssx_op_type op, input logic [3:0] pg);
		go(op, 8'h00);
		ck({ROM_REQ_OUT, BUSY_OUT, ROM_ADDR_OUT}, {2'h3, pg, 8'hA5});
		tick;
		tick;
		ROM_DATA_IN = 15'h5A3C;
		ROM_VALID_IN = '1;
		tick;
		ROM_VALID_IN = '0;
		ROM_DATA_IN = ~ROM_DATA_IN;
		ck({TABLE_HIGH_BYTE_OUT, MEM_WDATA_OUT}, 15'h5A3C);
		ck({DONE_OUT, MEM_WR_OUT, ROM_REQ_OUT}, 3'h6);
	endtask : rd_tab
	task automatic t_table;
		TABLE_POINTER_IN = 8'hA5;
		CUR_PAGE_IN = 4'h3;
		rd_tab(MSSX_OP_TABLE_READ_CURRENT_PAGE, 4'h3);
		rd_tab(MSSX_OP_TABLE_READ_LAST_PAGE, 4'hF);
		$display("table test done");
	endtask : t_table
	initial begin
		repeat (10) @(posedge CORE_CLK_IN);
		#1 RST_N_IN = '1;
		t_xor;
		t_swap;
		t_skip;
		t_table;
		stop_test;
	end
	initial begin
		repeat (300) @(posedge CORE_CLK_IN);
		error_cnt++;
		stop_test;
	end
endmodule : test_mcu_swap_skip_table_xor_ops
bind mssx_exec mssx_exec_props chk (
	.CORE_CLK_IN         (CORE_CLK_IN),
	.RST_N_IN            (RST_N_IN),
	.EXEC_VALID_IN       (EXEC_VALID_IN),
	.OP_IN               (OP_IN),
	.MEM_DATA_IN         (MEM_DATA_IN),
	.BIT_SEL_IN          (BIT_SEL_IN),
	.IMM_IN              (IMM_IN),
	.ROM_DATA_IN         (ROM_DATA_IN),
	.ROM_VALID_IN        (ROM_VALID_IN),
	.ACC_OUT             (ACC_OUT),
	.ZERO_FLAG_OUT       (ZERO_FLAG_OUT),
	.MEM_WR_OUT          (MEM_WR_OUT),
	.MEM_WDATA_OUT       (MEM_WDATA_OUT),
	.TABLE_HIGH_BYTE_OUT (TABLE_HIGH_BYTE_OUT),
	.ROM_REQ_OUT         (ROM_REQ_OUT),
	.SKIP_OUT            (SKIP_OUT),
	.BUSY_OUT            (BUSY_OUT),
	.DONE_OUT            (DONE_OUT)
);
`default_nettype wire
